// [rtl/bmg_device.sv]
`timescale 1ns/1ps
// Overview of operation
// - note is sid, tone, wait, pause bytes
// - timing bytes count 0..255 of 4 ms
// - note lasts wait time plus tone time plus pause time
// - pitches span octave 3 A to 8 G#
// - ids count semitones from 0 to 59
// - id selects fixed divisor from table
// - partial note at frame end is dropped
// - bytes dropped while note queue is full
// - queue holds exactly ten notes
// - read returns free slots, ten when empty
// - lone 0xFF stops play and flushes
// - host writes 0x78, 0x09, then notes
// - host reads free count via 0x79
module bmg_device
#(
   parameter int TICK_CYCLES = bmg_pkg::TICK_CYCLES
)
(
   input  logic             pclk,
   input  logic             presetn,
   bmg_link_if.dev_mp       link,
   output logic             buzz_out,
   output logic             playing
);
   import bmg_pkg::*;

   // ----------------------------------------------------------------
   // frame parser
   // ----------------------------------------------------------------
   bmg_hdr_t     hdr_reg;
   logic         frame_q_reg;
   logic         wr_mode_reg;
   logic         reg_sel_reg;
   logic         data_seen_reg;
   logic         ff_only_reg;
   logic [1:0]   nidx_reg;
   logic [23:0]  asm_reg;
   logic         rd_stb_reg;
   logic [7:0]   rd_data_reg;

   logic [31:0]  mem [0:9];
   logic [3:0]   wr_ptr_reg;
   logic [3:0]   rd_ptr_reg;
   logic [3:0]   count_reg;

   bmg_play_t    pl_reg;
   logic [31:0]  cur_reg;
   logic [7:0]   rem_reg;
   logic [19:0]  tick_cnt_reg;
   logic [7:0]   us_cnt_reg;
   logic [DIV_W-1:0] div_cnt_reg;
   logic         buzz_reg;
   logic         playing_reg;
   logic [DIV_W-1:0] div;

   wire          stb        = link.byte_stb;
   wire  [7:0]   bdat       = link.byte_data;
   wire          frame_end  = frame_q_reg & ~link.frame;
   wire          addr_byte  = stb & (hdr_reg == BMG_HDR_ADDR);
   wire          reg_byte   = stb & (hdr_reg == BMG_HDR_REG) & wr_mode_reg;
   wire          data_byte  = stb & (hdr_reg == BMG_HDR_DATA) & wr_mode_reg & reg_sel_reg;
   wire          note_done  = data_byte & (nidx_reg == NOTE_LAST_BYTE);
   wire          fifo_full  = (count_reg == FIFO_DEPTH);
   wire          push       = note_done & ~fifo_full;
   wire          flush      = frame_end & ff_only_reg;
   wire          pop        = (pl_reg == BMG_PL_IDLE) & (count_reg != 4'h0) & ~flush;
   wire  [7:0]   free_cnt   = {4'h0, FIFO_DEPTH - count_reg};
   wire  [31:0]  head       = mem[rd_ptr_reg[3:0]];
   wire          tick       = (tick_cnt_reg == 20'(TICK_CYCLES - 1));
   wire          rem_zero   = (rem_reg == 8'h00);
   wire          us_tick    = (us_cnt_reg == US_CYCLES - 8'h01);
   wire          tone_on    = (pl_reg == BMG_PL_TONE) & ~rem_zero;

   assign link.rd_stb  = rd_stb_reg;
   assign link.rd_data = rd_data_reg;
   assign buzz_out     = buzz_reg;
   assign playing      = playing_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         frame_q_reg   <= 1'b0;
         hdr_reg       <= BMG_HDR_ADDR;
         wr_mode_reg   <= 1'b0;
         reg_sel_reg   <= 1'b0;
      end
      else
      begin
         frame_q_reg <= link.frame;
         if (frame_end)
         begin
            hdr_reg     <= BMG_HDR_ADDR;
            wr_mode_reg <= 1'b0;
            reg_sel_reg <= 1'b0;
         end
         else if (addr_byte)
         begin
            hdr_reg     <= BMG_HDR_REG;
            wr_mode_reg <= (bdat == ADDR_WR);
         end
         else if (reg_byte)
         begin
            hdr_reg     <= BMG_HDR_DATA;
            reg_sel_reg <= (bdat == NOTE_REG);
         end
      end
   end

   // bytes gather into a note; the index is cleared by the frame's end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         nidx_reg      <= 2'h0;
         asm_reg       <= 24'h000000;
         data_seen_reg <= 1'b0;
         ff_only_reg   <= 1'b0;
      end
      else if (frame_end)
      begin
         nidx_reg      <= 2'h0;
         data_seen_reg <= 1'b0;
         ff_only_reg   <= 1'b0;
      end
      else if (data_byte)
      begin
         nidx_reg      <= nidx_reg + 2'h1;
         asm_reg       <= {asm_reg[15:0], bdat};
         data_seen_reg <= 1'b1;
         ff_only_reg   <= ~data_seen_reg & (bdat == STOP_BYTE);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rd_stb_reg  <= 1'b0;
         rd_data_reg <= FREE_RESET;
      end
      else
      begin
         rd_stb_reg <= addr_byte & (bdat == ADDR_RD);
         if (addr_byte & (bdat == ADDR_RD))
            rd_data_reg <= free_cnt;
      end
   end

   // ----------------------------------------------------------------
   // note queue
   // ----------------------------------------------------------------
   always_ff @(posedge pclk)
   begin
      if (push)
         mem[wr_ptr_reg] <= {asm_reg, bdat};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_ptr_reg <= 4'h0;
         rd_ptr_reg <= 4'h0;
         count_reg  <= 4'h0;
      end
      else if (flush)
      begin
         wr_ptr_reg <= 4'h0;
         rd_ptr_reg <= 4'h0;
         count_reg  <= 4'h0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= (wr_ptr_reg == FIFO_LAST) ? 4'h0 : wr_ptr_reg + 4'h1;
         if (pop)
            rd_ptr_reg <= (rd_ptr_reg == FIFO_LAST) ? 4'h0 : rd_ptr_reg + 4'h1;
         count_reg <= count_reg + {3'h0, push} - {3'h0, pop};
      end
   end

   // ----------------------------------------------------------------
   // player
   // ----------------------------------------------------------------
   bmg_divisor_rom u_rom
   (
      .sid (cur_reg[SID_LSB +: 8]),
      .div (div)
   );

   // tick phase restarts with each note so every duration is whole ticks
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tick_cnt_reg <= 20'h00000;
      else if (pop || (pl_reg == BMG_PL_IDLE) || tick)
         tick_cnt_reg <= 20'h00000;
      else
         tick_cnt_reg <= tick_cnt_reg + 20'h00001;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pl_reg      <= BMG_PL_IDLE;
         cur_reg     <= 32'h00000000;
         rem_reg     <= 8'h00;
         playing_reg <= 1'b0;
      end
      else
      begin
         playing_reg <= tone_on;
         if (flush)
            pl_reg <= BMG_PL_IDLE;
         else
         begin
            case (pl_reg)
               BMG_PL_IDLE:
                  if (pop)
                  begin
                     cur_reg <= head;
                     rem_reg <= head[WAIT_LSB +: 8];
                     pl_reg  <= BMG_PL_WAIT;
                  end
               BMG_PL_WAIT:
                  if (rem_zero)
                  begin
                     rem_reg <= cur_reg[TONE_LSB +: 8];
                     pl_reg  <= BMG_PL_TONE;
                  end
                  else if (tick)
                     rem_reg <= rem_reg - 8'h01;
               BMG_PL_TONE:
                  if (rem_zero)
                  begin
                     rem_reg <= cur_reg[PAUSE_LSB +: 8];
                     pl_reg  <= BMG_PL_PAUSE;
                  end
                  else if (tick)
                     rem_reg <= rem_reg - 8'h01;
               BMG_PL_PAUSE:
                  if (rem_zero)
                     pl_reg <= BMG_PL_IDLE;
                  else if (tick)
                     rem_reg <= rem_reg - 8'h01;
               default:
                  pl_reg <= BMG_PL_IDLE;
            endcase
         end
      end
   end

   // output toggles every div microseconds, idle low outside the tone
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         us_cnt_reg  <= 8'h00;
         div_cnt_reg <= 12'h000;
         buzz_reg    <= 1'b0;
      end
      else if (!tone_on || flush)
      begin
         us_cnt_reg  <= 8'h00;
         div_cnt_reg <= 12'h000;
         buzz_reg    <= 1'b0;
      end
      else
      begin
         us_cnt_reg <= us_tick ? 8'h00 : us_cnt_reg + 8'h01;
         if (us_tick && (div != 12'h000))
         begin
            if (div_cnt_reg == div - 12'h001)
            begin
               div_cnt_reg <= 12'h000;
               buzz_reg    <= ~buzz_reg;
            end
            else
               div_cnt_reg <= div_cnt_reg + 12'h001;
         end
      end
   end
endmodule

// [rtl/bmg_pkg.sv]
package bmg_pkg;
   // ----------------------------------------------------------------
   // link bytes and device register
   // ----------------------------------------------------------------
   localparam logic [7:0]  ADDR_WR        = 8'h78;
   localparam logic [7:0]  ADDR_RD        = 8'h79;
   localparam logic [7:0]  NOTE_REG       = 8'h09;
   localparam logic [7:0]  MELODY_OFFSET  = 8'h0A;
   localparam logic [7:0]  STOP_BYTE      = 8'hFF;
   localparam logic [7:0]  FREE_RESET     = 8'h0A;
   localparam logic [3:0]  FIFO_DEPTH     = 4'hA;
   localparam logic [3:0]  FIFO_LAST      = 4'h9;
   localparam logic [1:0]  NOTE_LAST_BYTE = 2'h3;
   localparam int          DIV_W          = 12;

   // note word layout: {scale id, tone_time, wait_time, pause_time}
   localparam int          SID_LSB        = 24;
   localparam int          TONE_LSB       = 16;
   localparam int          WAIT_LSB       = 8;
   localparam int          PAUSE_LSB      = 0;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int          CLK_NS         = 5;
   localparam int          TICK_MS        = 4;
   localparam int          TICK_CYCLES    = (TICK_MS * 1000000) / CLK_NS;
   localparam int          US_NS          = 1000;
   localparam logic [7:0]  US_CYCLES      = 8'((US_NS + CLK_NS - 1) / CLK_NS);

   // ----------------------------------------------------------------
   // host controller registers
   // ----------------------------------------------------------------
   localparam logic [11:0] HOST_NOTE_OFF  = 12'h000;
   localparam logic [11:0] HOST_CTRL_OFF  = 12'h004;
   localparam logic [11:0] HOST_STAT_OFF  = 12'h008;
   localparam int          CTRL_STOP_BIT  = 0;
   localparam int          CTRL_READ_BIT  = 1;
   localparam int          STAT_BUSY_BIT  = 0;
   localparam int          STAT_FREE_LSB  = 8;
   localparam logic [2:0]  NOTE_FRAME_LEN = 3'h6;
   localparam logic [2:0]  STOP_FRAME_LEN = 3'h3;
   localparam logic [2:0]  READ_FRAME_LEN = 3'h1;

   // ----------------------------------------------------------------
   // state types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {BMG_HDR_ADDR, BMG_HDR_REG, BMG_HDR_DATA} bmg_hdr_t;
   typedef enum logic [1:0] {BMG_PL_IDLE, BMG_PL_WAIT, BMG_PL_TONE, BMG_PL_PAUSE} bmg_play_t;
   typedef enum logic [1:0] {BMG_H_IDLE, BMG_H_SEND, BMG_H_WAITRD, BMG_H_END} bmg_hst_t;
endpackage

// [rtl/bmg_link_if.sv]
`timescale 1ns/1ps
// byte-level view of the serial link: frame spans start to stop
interface bmg_link_if;
   logic       frame;
   logic       byte_stb;
   logic [7:0] byte_data;
   logic       rd_stb;
   logic [7:0] rd_data;

   modport host_mp (output frame, output byte_stb, output byte_data,
                    input rd_stb, input rd_data);
   modport dev_mp  (input frame, input byte_stb, input byte_data,
                    output rd_stb, output rd_data);
endinterface

// [rtl/bmg_divisor_rom.sv]
`timescale 1ns/1ps
// half period of the tone in microseconds; unknown ids give zero (silent)
module bmg_divisor_rom
(
   input  logic [7:0]                 sid,
   output logic [bmg_pkg::DIV_W-1:0]  div
);
   import bmg_pkg::*;

   always_comb
   begin
      case (sid)
         8'h00: div = 12'h8E1;
         8'h01: div = 12'h861;
         8'h02: div = 12'h7E9;
         8'h03: div = 12'h777;
         8'h04: div = 12'h70C;
         8'h05: div = 12'h6A7;
         8'h06: div = 12'h647;
         8'h07: div = 12'h5ED;
         8'h08: div = 12'h598;
         8'h09: div = 12'h547;
         8'h0A: div = 12'h4FC;
         8'h0B: div = 12'h4B4;
         8'h0C: div = 12'h470;
         8'h0D: div = 12'h431;
         8'h0E: div = 12'h3F4;
         8'h0F: div = 12'h3BC;
         8'h10: div = 12'h386;
         8'h11: div = 12'h353;
         8'h12: div = 12'h324;
         8'h13: div = 12'h2F6;
         8'h14: div = 12'h2CC;
         8'h15: div = 12'h2A4;
         8'h16: div = 12'h27E;
         8'h17: div = 12'h25A;
         8'h18: div = 12'h238;
         8'h19: div = 12'h218;
         8'h1A: div = 12'h1FA;
         8'h1B: div = 12'h1DE;
         8'h1C: div = 12'h1C3;
         8'h1D: div = 12'h1AA;
         8'h1E: div = 12'h192;
         8'h1F: div = 12'h17B;
         8'h20: div = 12'h166;
         8'h21: div = 12'h152;
         8'h22: div = 12'h13F;
         8'h23: div = 12'h12D;
         8'h24: div = 12'h11C;
         8'h25: div = 12'h10C;
         8'h26: div = 12'h0FD;
         8'h27: div = 12'h0EF;
         8'h28: div = 12'h0E1;
         8'h29: div = 12'h0D5;
         8'h2A: div = 12'h0C9;
         8'h2B: div = 12'h0BE;
         8'h2C: div = 12'h0B3;
         8'h2D: div = 12'h0A9;
         8'h2E: div = 12'h09F;
         8'h2F: div = 12'h096;
         8'h30: div = 12'h08E;
         8'h31: div = 12'h086;
         8'h32: div = 12'h07F;
         8'h33: div = 12'h077;
         8'h34: div = 12'h071;
         8'h35: div = 12'h06A;
         8'h36: div = 12'h064;
         8'h37: div = 12'h05F;
         8'h38: div = 12'h059;
         8'h39: div = 12'h054;
         8'h3A: div = 12'h050;
         8'h3B: div = 12'h04B;
         default: div = 12'h000;
      endcase
   end
endmodule

// [rtl/bmg_host.sv]
`timescale 1ns/1ps
module bmg_host
(
   input  logic             pclk,
   input  logic             presetn,
   input  logic             psel,
   input  logic             penable,
   input  logic             pwrite,
   input  logic [11:0]      paddr,
   input  logic [31:0]      pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   bmg_link_if.host_mp      link
);
   import bmg_pkg::*;

   // ----------------------------------------------------------------
   // apb slave, one wait state
   // ----------------------------------------------------------------
   bmg_hst_t     st_reg;
   logic [47:0]  buf_reg;
   logic [2:0]   n_reg;
   logic         is_read_reg;
   logic [7:0]   free_reg;
   logic         frame_reg;
   logic         stb_reg;
   logic [7:0]   data_reg;
   logic [31:0]  prdata_reg;
   logic         pready_reg;
   logic         pslverr_reg;

   wire          access   = psel & penable & ~pready_reg;
   wire          done     = psel & penable & pready_reg;
   wire          hit_note = (paddr == HOST_NOTE_OFF);
   wire          hit_ctrl = (paddr == HOST_CTRL_OFF);
   wire          hit_stat = (paddr == HOST_STAT_OFF);
   wire          mapped   = hit_note | hit_ctrl | hit_stat;
   wire          idle     = (st_reg == BMG_H_IDLE);
   // orders arriving while a frame is out are dropped; software polls busy
   wire          wr_note  = done & pwrite & hit_note & idle;
   wire          wr_stop  = done & pwrite & hit_ctrl & idle & pwdata[CTRL_STOP_BIT];
   wire          wr_read  = done & pwrite & hit_ctrl & idle & pwdata[CTRL_READ_BIT];
   // busy is widened by concatenation, a size cast would invert the padding bits too
   wire  [31:0]  stat_val = ({24'h000000, free_reg} << STAT_FREE_LSB) |
                            ({31'h00000000, ~idle} << STAT_BUSY_BIT);

   assign prdata    = prdata_reg;
   assign pready    = pready_reg;
   assign pslverr   = pslverr_reg;
   assign link.frame     = frame_reg;
   assign link.byte_stb  = stb_reg;
   assign link.byte_data = data_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
      end
      else
      begin
         pready_reg  <= access;
         pslverr_reg <= access & ~mapped;
         prdata_reg  <= (access & ~pwrite & hit_stat) ? stat_val : 32'h00000000;
      end
   end

   // ----------------------------------------------------------------
   // frame sequencer, one byte per clock
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_reg      <= BMG_H_IDLE;
         buf_reg     <= 48'h000000000000;
         n_reg       <= 3'h0;
         is_read_reg <= 1'b0;
         free_reg    <= FREE_RESET;
         frame_reg   <= 1'b0;
         stb_reg     <= 1'b0;
         data_reg    <= 8'h00;
      end
      else
      begin
         case (st_reg)
            BMG_H_IDLE:
               if (wr_note)
               begin
                  buf_reg     <= {ADDR_WR, NOTE_REG, pwdata};
                  n_reg       <= NOTE_FRAME_LEN;
                  is_read_reg <= 1'b0;
                  frame_reg   <= 1'b1;
                  st_reg      <= BMG_H_SEND;
               end
               else if (wr_stop)
               begin
                  buf_reg     <= {ADDR_WR, NOTE_REG, STOP_BYTE, 24'h000000};
                  n_reg       <= STOP_FRAME_LEN;
                  is_read_reg <= 1'b0;
                  frame_reg   <= 1'b1;
                  st_reg      <= BMG_H_SEND;
               end
               else if (wr_read)
               begin
                  buf_reg     <= {ADDR_RD, 40'h0000000000};
                  n_reg       <= READ_FRAME_LEN;
                  is_read_reg <= 1'b1;
                  frame_reg   <= 1'b1;
                  st_reg      <= BMG_H_SEND;
               end
            BMG_H_SEND:
            begin
               stb_reg  <= 1'b1;
               data_reg <= buf_reg[47:40];
               buf_reg  <= {buf_reg[39:0], 8'h00};
               n_reg    <= n_reg - 3'h1;
               if (n_reg == 3'h1)
                  st_reg <= is_read_reg ? BMG_H_WAITRD : BMG_H_END;
            end
            BMG_H_WAITRD:
            begin
               stb_reg <= 1'b0;
               if (link.rd_stb)
               begin
                  free_reg <= link.rd_data;
                  st_reg   <= BMG_H_END;
               end
            end
            BMG_H_END:
            begin
               stb_reg   <= 1'b0;
               frame_reg <= 1'b0;
               st_reg    <= BMG_H_IDLE;
            end
            default:
               st_reg <= BMG_H_IDLE;
         endcase
      end
   end
endmodule

// [sim/bmg_monitor.sv]
`timescale 1ns/1ps
module bmg_monitor
(
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       frame,
   input wire logic       byte_stb,
   input wire logic [7:0] byte_data,
   input wire logic       rd_stb,
   input wire logic [7:0] rd_data,
   input wire logic       buzz_out,
   input wire logic       playing
);
   import bmg_pkg::*;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ----------------------------------------------------------------
   // link framing
   // ----------------------------------------------------------------
   a_stb_in_frame: assert property (byte_stb |-> frame)
      else $error("byte strobe outside frame");
   a_first_addr: assert property ($rose(frame) |=> byte_stb &&
      (byte_data == ADDR_WR || byte_data == ADDR_RD))
      else $error("frame does not open with an address");
   a_reg_byte: assert property ($rose(frame) ##1 (byte_stb &&
      byte_data == ADDR_WR) |=> byte_stb && byte_data == NOTE_REG)
      else $error("register byte missing after write address");
   // a stop frame carries 0xFF as third byte, so it never matches here
   a_note_bytes: assert property ($rose(frame) ##1 (byte_stb &&
      byte_data == ADDR_WR) ##1 byte_stb ##1 (byte_stb && byte_data != STOP_BYTE)
      |=> byte_stb [*3] ##1 !byte_stb)
      else $error("note frame not four data bytes");
   // ----------------------------------------------------------------
   // free count answer and buzzer
   // ----------------------------------------------------------------
   // only the first byte of a frame is an address; note bytes may equal it
   a_read_answer: assert property ($rose(frame) ##1 (byte_stb &&
      byte_data == ADDR_RD) |=> rd_stb)
      else $error("no answer to read address");
   a_rd_cause: assert property (rd_stb |->
      $past(byte_stb) && $past(byte_data) == ADDR_RD)
      else $error("answer without read address");
   a_free_range: assert property (rd_stb |-> rd_data <= 8'h0A)
      else $error("free count above ten");
   a_buzz_in_tone: assert property ($rose(buzz_out) |-> playing)
      else $error("buzzer toggles outside tone");
   a_buzz_rest: assert property ($fell(playing) |-> ##[0:2] !buzz_out)
      else $error("buzzer not idle after tone");
endmodule

// [sim/buzzer_melody_generator_tb.sv]
`timescale 1ns/1ps
module buzzer_melody_generator_tb;
   import bmg_pkg::*;
   localparam int TICK = 200;
   typedef struct packed {logic w; logic [11:0] a; logic [31:0] d;
                          logic [31:0] q; logic e;} bmg_row_t;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic [31:0] rd_word;
   logic        pready;
   logic        pslverr;
   logic        err_seen;
   logic        buzz_out;
   logic        playing;
   int          n_mismatch;
   int          checks_done;
   int          n;
   int          t_buzz;
   bmg_row_t    rows [5];
   bmg_link_if  link();
   bmg_host i_bmg_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link));
   bmg_device #(.TICK_CYCLES(TICK)) i_bmg_device (.pclk(pclk), .presetn(presetn),
      .link(link), .buzz_out(buzz_out), .playing(playing));
   bmg_monitor i_bmg_monitor (.pclk(pclk), .presetn(presetn), .frame(link.frame),
      .byte_stb(link.byte_stb), .byte_data(link.byte_data), .rd_stb(link.rd_stb),
      .rd_data(link.rd_data), .buzz_out(buzz_out), .playing(playing));
   // ----------------------------------------------------------------
   // bench tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic hang(input string what);
      n_mismatch++;
      $display("wrong value %s expected done seen timeout", what);
      finish_test();
   endtask
   // request holds until the edge that samples pready high; the answer is taken there
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k >= 50)
         hang("pready");
      rd_word = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic idle();
      int k;
      k = 0;
      do
      begin
         apb(1'b0, HOST_STAT_OFF, 32'h0);
         k++;
      end
      while (rd_word[STAT_BUSY_BIT] !== 1'b0 && k < 100);
      if (k >= 100)
         hang("busy");
   endtask
   task automatic order(input logic [11:0] a, input logic [31:0] d);
      idle();
      apb(1'b1, a, d);
      idle();
   endtask
   task automatic free_is(input logic [7:0] exp);
      order(HOST_CTRL_OFF, 32'h2);
      apb(1'b0, HOST_STAT_OFF, 32'h0);
      check("free", {24'h0, rd_word[15:8]}, {24'h0, exp});
   endtask
   initial
   begin
      pclk = 1'b0;
      forever
         #2.5 pclk = ~pclk;
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      n_mismatch = 0;
      checks_done = 0;
      rows[0] = {1'b0, HOST_STAT_OFF, 32'h0, 32'h0000_0A00, 1'b0};
      rows[1] = {1'b0, HOST_NOTE_OFF, 32'h0, 32'h0, 1'b0};
      rows[2] = {1'b0, HOST_CTRL_OFF, 32'h0, 32'h0, 1'b0};
      rows[3] = {1'b1, 12'h00C, 32'h5, 32'h0, 1'b1};
      rows[4] = {1'b0, 12'h00C, 32'h0, 32'h0, 1'b1};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      foreach (rows[i])
      begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         check("rdata", rd_word, rows[i].q);
         check("slverr", {31'h0, err_seen}, {31'h0, rows[i].e});
      end
      check("link rd_data", {24'h0, link.rd_data}, {24'h0, FREE_RESET});
      $display("register rows done");
      // first note rests in its pause while eleven more overfill the queue
      order(HOST_NOTE_OFF, 32'h0000_0064);
      for (int i = 0; i < 11; i++)
         order(HOST_NOTE_OFF, 32'h0C01_0101);
      free_is(8'h00);
      order(HOST_CTRL_OFF, 32'h3);
      free_is(8'h0A);
      check("playing", {31'h0, playing}, 32'h0);
      $display("fill and stop done");
      // highest pitch, wait of 5 ticks, tone of 100 ticks, no pause
      order(HOST_NOTE_OFF, 32'h3B64_0500);
      n = 0;
      while (playing !== 1'b1 && n < 2000)
      begin
         @(negedge pclk);
         n++;
      end
      if (n >= 2000)
         hang("playing");
      check("wait len", {31'h0, n >= 5 * TICK - 10 && n <= 5 * TICK + 5}, 32'h1);
      n = 0;
      t_buzz = 0;
      while (playing === 1'b1 && n < 30000)
      begin
         @(negedge pclk);
         n++;
         if (t_buzz == 0 && buzz_out === 1'b1)
            t_buzz = n;
      end
      check("tone len", {31'h0, n >= 100 * TICK - 5 && n <= 100 * TICK + 5}, 32'h1);
      check("half period", {31'h0, t_buzz >= 14995 && t_buzz <= 15005}, 32'h1);
      @(negedge pclk);
      check("buzz rest", {31'h0, buzz_out}, 32'h0);
      free_is(8'h0A);
      $display("tone done");
      // stop in mid-tone silences at once and drops the note still queued
      order(HOST_NOTE_OFF, 32'h0C64_0000);
      order(HOST_NOTE_OFF, 32'h0C64_0000);
      repeat (100) @(posedge pclk);
      check("tone before stop", {31'h0, playing}, 32'h1);
      order(HOST_CTRL_OFF, 32'h1);
      free_is(8'h0A);
      check("stop playing", {31'h0, playing}, 32'h0);
      check("stop buzz", {31'h0, buzz_out}, 32'h0);
      // reset in mid-tone: outputs idle at once, queue empty after release
      order(HOST_NOTE_OFF, 32'h0C64_0000);
      repeat (100) @(posedge pclk);
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      check("reset playing", {31'h0, playing}, 32'h0);
      check("reset buzz", {31'h0, buzz_out}, 32'h0);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      free_is(8'h0A);
      $display("stop and reset done");
      finish_test();
   end
endmodule
